//--- common/cssq_pkg.sv
// Purpose: Shared constants and types for the converter start-up sequencer
// Assumes: 40 MHz clock, classic Wishbone slave with 32-bit data
// Notes: Register offsets are byte addresses of aligned words
package cssq_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  // Soft-start ramp durations in microseconds
  localparam int unsigned RAMP_US_2MHZ = 400;
  localparam int unsigned RAMP_US_3MHZ = 250;
  localparam int unsigned RAMP_CYC_2MHZ = RAMP_US_2MHZ * (CLK_HZ / 1000000);
  localparam int unsigned RAMP_CYC_3MHZ = RAMP_US_3MHZ * (CLK_HZ / 1000000);
  // Cycles in the second state of the sequence, ST_PREP
  localparam int unsigned SETTLE_CYC = 16;
  localparam int unsigned REF_W = 12;
  // Bandgap level on the reference scale; ramp ends just above it
  localparam logic [11:0] BANDGAP_REF = 12'hc00;
  localparam logic [11:0] REF_STEP = 12'h001;

  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_EVT = 8'h04;
  localparam logic [7:0] ADR_EVT_CLR = 8'h08;
  localparam logic [7:0] ADR_EVT_EN = 8'h0c;
  localparam logic [7:0] ADR_CTRL = 8'h10;
  localparam logic [7:0] ADR_REF = 8'h14;
  localparam int unsigned EVT_W = 5;
  localparam logic [4:0] EVT_RESET = 5'h00;
  localparam logic [0:0] CTRL_RESET = 1'h0;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_PREP,
    ST_RAMP,
    ST_REG
  } cssq_state_t;

  // Digitised comparator results after synchronisation
  typedef struct packed {
    logic ctrl_ok;
    logic gate_ok;
    logic en_raw;
    logic pol_n;
    logic over_temp;
    logic win_ok;
  } cssq_cmp_t;

  // Sticky events: off, regulating, gate lockout, over-temp, window lost
  typedef struct packed {
    logic win_lost;
    logic ot_trip;
    logic gate_lock;
    logic reg_reached;
    logic shut_down;
  } cssq_evt_t;
endpackage

//--- rtl/cssq_sync.sv
// Purpose: Two-flop synchroniser for a vector of pin levels
// Assumes: Inputs asynchronous to clk_i
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module cssq_sync #(
  parameter int unsigned W = 6,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else if (ce_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule
`default_nettype wire

//--- rtl/cssq_top.sv
// Purpose: Start-up and protection sequencer of a buck converter controller
// Assumes: Comparator results arrive as digital levels; 40 MHz clk_i
// Notes: Registers reached over classic Wishbone
// Behaviour
// - Stay inactive until control supply lockout clears
// - Start ramp only above gate supply threshold
// - Normal polarity: on high enable, off low
// - Floating enable means off in normal polarity
// - Grounded polarity strap inverts enable sense
// - Ramp reference gradually, 400us or 250us
// - Any disable repeats full start-up sequence
// - Four-state two-bit machine, ramp in third
// - Ramp ends above bandgap, switch to bandgap
// - Regulation flag low when off, reset, out-of-window
// - Shut down on over-temperature indication
// - Restart with ramp when temperature clears
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module cssq_top #(
  parameter int unsigned SETTLE = cssq_pkg::SETTLE_CYC,
  parameter int unsigned RAMP_2M = cssq_pkg::RAMP_CYC_2MHZ,
  parameter int unsigned RAMP_3M = cssq_pkg::RAMP_CYC_3MHZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Comparator levels, asynchronous
  input wire logic ctrl_supply_ok_i,
  input wire logic gate_supply_ok_i,
  input wire logic enable_pin_i,
  input wire logic polarity_strap_n_i,
  input wire logic over_temp_i,
  input wire logic out_window_ok_i,
  // Wishbone classic
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic int_o,
  // Converter controls
  output logic converter_on_o,
  output logic use_bandgap_o,
  output logic [cssq_pkg::REF_W-1:0] error_amplifier_ref_o,
  output logic [1:0] state_o,
  // Open-drain regulation flag: oe high pulls the pin low
  output logic regulation_ok_output_o,
  output logic regulation_ok_output_oe_o
);
  localparam int unsigned RW = cssq_pkg::REF_W;
  // Cycles per reference step; the ramp climbs to bandgap over the duration
  localparam int unsigned DIV_2M = (RAMP_2M / int'(cssq_pkg::BANDGAP_REF)) > 0 ?
    RAMP_2M / int'(cssq_pkg::BANDGAP_REF) : 1;
  localparam int unsigned DIV_3M = (RAMP_3M / int'(cssq_pkg::BANDGAP_REF)) > 0 ?
    RAMP_3M / int'(cssq_pkg::BANDGAP_REF) : 1;

  cssq_pkg::cssq_cmp_t raw_s;
  cssq_pkg::cssq_cmp_t cmp_s;

  assign raw_s = '{ctrl_ok: ctrl_supply_ok_i, gate_ok: gate_supply_ok_i,
                   en_raw: enable_pin_i, pol_n: polarity_strap_n_i,
                   over_temp: over_temp_i, win_ok: out_window_ok_i};

  // Strap resets to its floating value, normal polarity
  cssq_sync #(
    .W(6),
    .INIT(6'h04 | 6'h00)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(raw_s),
    .q_o(cmp_s)
  );

  // Floating pin reads low via pull-down: off when normal, on when inverted
  logic enable_req;
  assign enable_req = cmp_s.pol_n ? cmp_s.en_raw : !cmp_s.en_raw;

  // Comparators carry their own hysteresis; here only the levels are read
  logic [0:0] ctrl_hold_q;
  logic run_ok;
  assign run_ok = cmp_s.ctrl_ok && cmp_s.gate_ok && enable_req &&
                  !cmp_s.over_temp && !ctrl_hold_q;

  logic fast_sw_q;
  cssq_pkg::cssq_state_t state_q;
  logic [15:0] cnt_q;
  logic [RW-1:0] ref_q;
  cssq_pkg::cssq_evt_t evt_q;
  logic [4:0] evt_en_q;

  function automatic logic [15:0] step_div(input logic fast);
    step_div = fast ? 16'(DIV_3M) : 16'(DIV_2M);
  endfunction

  // Start-up state machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= cssq_pkg::ST_OFF;
      cnt_q <= 16'h0000;
      ref_q <= '0;
    end else if (ce_i) begin
      if (!run_ok) begin
        state_q <= cssq_pkg::ST_OFF;
        cnt_q <= 16'h0000;
        ref_q <= '0;
      end else begin
        case (state_q)
          cssq_pkg::ST_OFF: begin
            cnt_q <= 16'h0000;
            ref_q <= '0;
            state_q <= cssq_pkg::ST_PREP;
          end
          cssq_pkg::ST_PREP: begin
            if (cnt_q == 16'(SETTLE - 1)) begin
              cnt_q <= 16'h0000;
              state_q <= cssq_pkg::ST_RAMP;
            end else begin
              cnt_q <= cnt_q + 16'h0001;
            end
          end
          cssq_pkg::ST_RAMP: begin
            if (ref_q > cssq_pkg::BANDGAP_REF) begin
              state_q <= cssq_pkg::ST_REG;
            end else if (cnt_q >= step_div(fast_sw_q) - 16'h0001) begin
              cnt_q <= 16'h0000;
              ref_q <= ref_q + cssq_pkg::REF_STEP;
            end else begin
              cnt_q <= cnt_q + 16'h0001;
            end
          end
          cssq_pkg::ST_REG: begin
            ref_q <= cssq_pkg::BANDGAP_REF;
          end
          default: state_q <= cssq_pkg::ST_OFF;
        endcase
      end
    end
  end

  // Outputs registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      converter_on_o <= 1'b0;
      use_bandgap_o <= 1'b0;
      error_amplifier_ref_o <= '0;
      state_o <= 2'h0;
      regulation_ok_output_o <= 1'b0;
      regulation_ok_output_oe_o <= 1'b1;
    end else if (ce_i) begin
      converter_on_o <= run_ok && state_q != cssq_pkg::ST_OFF;
      use_bandgap_o <= state_q == cssq_pkg::ST_REG;
      error_amplifier_ref_o <= state_q == cssq_pkg::ST_REG ? cssq_pkg::BANDGAP_REF : ref_q;
      state_o <= state_q;
      regulation_ok_output_o <= 1'b0;
      // Released only while regulating and in window
      regulation_ok_output_oe_o <= !(run_ok && state_q == cssq_pkg::ST_REG &&
                                     cmp_s.win_ok);
    end
  end

  // Events, set beats clear
  cssq_pkg::cssq_evt_t evt_set;
  logic reg_prev_q;
  logic run_prev_q;
  logic wb_wr;
  logic wb_rd;
  assign wb_wr = cyc_i && stb_i && we_i && !ack_o;
  assign wb_rd = cyc_i && stb_i && !we_i && !ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_prev_q <= 1'b0;
      run_prev_q <= 1'b0;
    end else if (ce_i) begin
      reg_prev_q <= state_q == cssq_pkg::ST_REG;
      run_prev_q <= run_ok;
    end
  end

  always_comb begin
    evt_set.shut_down = run_prev_q && !run_ok;
    evt_set.reg_reached = !reg_prev_q && state_q == cssq_pkg::ST_REG;
    evt_set.gate_lock = run_prev_q && !cmp_s.gate_ok;
    evt_set.ot_trip = run_prev_q && cmp_s.over_temp;
    evt_set.win_lost = state_q == cssq_pkg::ST_REG && !cmp_s.win_ok && reg_prev_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_q <= cssq_pkg::EVT_RESET;
    end else if (ce_i) begin
      if (wb_wr && adr_i == cssq_pkg::ADR_EVT_CLR && sel_i[0]) begin
        evt_q <= (evt_q & ~dat_i[4:0]) | evt_set;
      end else begin
        evt_q <= evt_q | evt_set;
      end
    end
  end

  // Writable control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_en_q <= cssq_pkg::EVT_RESET;
      fast_sw_q <= 1'b0;
      ctrl_hold_q <= cssq_pkg::CTRL_RESET;
    end else if (ce_i && wb_wr && sel_i[0]) begin
      if (adr_i == cssq_pkg::ADR_EVT_EN) begin
        evt_en_q <= dat_i[4:0];
      end
      if (adr_i == cssq_pkg::ADR_CTRL) begin
        fast_sw_q <= dat_i[0];
        ctrl_hold_q <= dat_i[1];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_o <= 1'b0;
    end else if (ce_i) begin
      int_o <= |(evt_q & evt_en_q);
    end
  end

  // Bus answers one cycle after the request, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= cyc_i && stb_i && !ack_o;
      dat_o <= 32'h0000_0000;
      if (wb_rd) begin
        case (adr_i)
          cssq_pkg::ADR_STATUS: dat_o <= {24'h000000, cmp_s.win_ok, cmp_s.over_temp,
                                          enable_req, cmp_s.gate_ok, cmp_s.ctrl_ok,
                                          run_ok, state_q};
          cssq_pkg::ADR_EVT: dat_o <= {27'h0000000, evt_q};
          cssq_pkg::ADR_EVT_EN: dat_o <= {27'h0000000, evt_en_q};
          cssq_pkg::ADR_CTRL: dat_o <= {30'h00000000, ctrl_hold_q, fast_sw_q};
          cssq_pkg::ADR_REF: dat_o <= {20'h00000, ref_q};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Checks
  a_fault_to_off: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !run_ok |=> state_q == cssq_pkg::ST_OFF)
    else $error("fault did not return to off");
  a_flag_only_reg: assert property (@(posedge clk_i) disable iff (rst_i)
    !regulation_ok_output_oe_o |-> state_o == 2'h3)
    else $error("flag released outside regulation");
  a_ramp_order: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_q == cssq_pkg::ST_REG && $past(state_q) != cssq_pkg::ST_REG
    |-> $past(state_q) == cssq_pkg::ST_RAMP)
    else $error("regulation entered without ramp");
  a_ramp_above_bg: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_q == cssq_pkg::ST_RAMP ##1 state_q == cssq_pkg::ST_REG
    |-> ref_q > cssq_pkg::BANDGAP_REF)
    else $error("ramp ended below bandgap");
  a_ref_monotone: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_q == cssq_pkg::ST_RAMP && run_ok |=> ref_q >= $past(ref_q))
    else $error("reference fell during ramp");
  a_ot_off: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cmp_s.over_temp |=> !converter_on_o)
    else $error("over-temperature left converter on");
  a_gate_off: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !cmp_s.gate_ok |=> ##1 regulation_ok_output_oe_o)
    else $error("gate lockout kept flag released");
  a_enable_sense: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && cmp_s.pol_n && !cmp_s.en_raw |=> !converter_on_o)
    else $error("low enable left converter on");
  a_inverted_sense: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !cmp_s.pol_n && cmp_s.en_raw |=> !converter_on_o)
    else $error("inverted high enable left converter on");
  a_ctrl_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !cmp_s.ctrl_ok |=> state_q == cssq_pkg::ST_OFF)
    else $error("control lockout ignored");
  c_reach_reg: cover property (@(posedge clk_i) disable iff (rst_i)
    state_q == cssq_pkg::ST_RAMP ##1 state_q == cssq_pkg::ST_REG);
  c_ot_restart: cover property (@(posedge clk_i) disable iff (rst_i)
    cmp_s.over_temp ##1 !cmp_s.over_temp ##1 state_q == cssq_pkg::ST_PREP);
  c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(int_o));
endmodule
`default_nettype wire

//--- tb/cssq_partner.sv
// Purpose: Enable driver and power stage seen by the sequencer
// Assumes: Output settles into the window a few cycles after bandgap switch
// Notes: Enable pin follows the request directly; no pull-down is modelled
`timescale 1ns/1ps
`default_nettype none
module cssq_partner #(
  parameter int unsigned WIN_DLY = 4
) (
  input wire logic clk_i,
  input wire logic en_req_i,
  input wire logic win_fault_i,
  input wire logic converter_on_i,
  input wire logic use_bandgap_i,
  output logic enable_pin_o,
  output logic out_window_ok_o
);
  int unsigned cnt_q;
  // Supply stays applied; only the enable level toggles
  assign enable_pin_o = en_req_i;
  always_ff @(posedge clk_i) begin
    if (!(converter_on_i && use_bandgap_i)) cnt_q <= 0;
    else if (cnt_q < WIN_DLY) cnt_q <= cnt_q + 1;
  end
  // Fault input lets a test pull the output out of its window
  assign out_window_ok_o = (cnt_q == WIN_DLY) && !win_fault_i;
endmodule
`default_nettype wire

//--- tb/tb_cssq_top.sv
// Purpose: Self-checking bench of the start-up sequencer
// Assumes: Ramp shortened: a step every two cycles, every cycle in fast mode
// Notes: Outputs read after an edge hold the values sampled at it
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
  $display("FAIL t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_cssq_top;
  logic clk_i = 0, rst_i = 1, ctrl = 0, gate = 0, en_req = 0, strap_n = 1, ot = 0, wf = 0;
  logic cyc = 0, stb = 0, we = 0, ce = 1;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, dat_o, q;
  logic ack_o, int_o, conv_on, bg, win_ok, en_pin, oe, od;
  logic [11:0] ref_o, r0;
  logic [1:0] state_o;
  int num_errors = 0, tests_run = 0;
  initial forever #12.5 clk_i = ~clk_i;
  cssq_top #(.SETTLE(4), .RAMP_2M(6144), .RAMP_3M(3073)) u_cssq_top (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .ctrl_supply_ok_i(ctrl),
    .gate_supply_ok_i(gate), .enable_pin_i(en_pin), .polarity_strap_n_i(strap_n),
    .over_temp_i(ot), .out_window_ok_i(win_ok), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .int_o(int_o),
    .converter_on_o(conv_on), .use_bandgap_o(bg), .error_amplifier_ref_o(ref_o),
    .state_o(state_o), .regulation_ok_output_o(od), .regulation_ok_output_oe_o(oe));
  cssq_partner u_cssq_partner (.clk_i(clk_i), .en_req_i(en_req), .win_fault_i(wf),
    .converter_on_i(conv_on), .use_bandgap_i(bg), .enable_pin_o(en_pin),
    .out_window_ok_o(win_ok));
  // Waits for ack however long it takes; only the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    sel <= 4'h0;
    @(posedge clk_i);
  endtask
  task automatic wait_st(input logic [1:0] s, input int lim);
    int n;
    n = 0;
    while (state_o !== s && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(state_o, s)
  endtask
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    ctrl <= 1;
    gate <= 1;
    repeat (10) @(posedge clk_i);
    `CHK(state_o, 2'h0)
    `CHK(conv_on, 1'b0)
    `CHK(oe, 1'b1)
    `CHK(od, 1'b0)
    // Lockout and enable swap on one edge, so run is never granted
    ctrl <= 0;
    en_req <= 1;
    repeat (10) @(posedge clk_i);
    `CHK(state_o, 2'h0)
    ctrl <= 1;
    wait_st(2'h1, 10);
    `CHK(conv_on, 1'b1)
    wait_st(2'h2, 20);
    r0 = ref_o;
    repeat (10) @(posedge clk_i);
    `CHK(ref_o - r0, 12'h005)
    `CHK(oe, 1'b1)
    // Clock enable low freezes the ramp
    ce <= 0;
    @(posedge clk_i);
    r0 = ref_o;
    repeat (5) @(posedge clk_i);
    `CHK(ref_o, r0)
    `CHK(state_o, 2'h2)
    ce <= 1;
    wait_st(2'h3, 6300);
    `CHK(ref_o, 12'hc00)
    `CHK(bg, 1'b1)
    repeat (8) @(posedge clk_i);
    `CHK(oe, 1'b0)
    wf <= 1;
    repeat (4) @(posedge clk_i);
    `CHK(oe, 1'b1)
    `CHK(state_o, 2'h3)
    `CHK(conv_on, 1'b1)
    wf <= 0;
    $display("Test start-up done");
    wb(0, 8'h10, 32'h0);
    `CHK(q, 32'h0)
    wb(1, 8'h0c, 32'h02);
    repeat (2) @(posedge clk_i);
    `CHK(int_o, 1'b1)
    wb(0, 8'h04, 32'h0);
    `CHK(q[1], 1'b1)
    wb(1, 8'h0c, 32'h00);
    repeat (2) @(posedge clk_i);
    `CHK(int_o, 1'b0)
    wb(1, 8'h0c, 32'h02);
    wb(1, 8'h08, 32'h02);
    repeat (2) @(posedge clk_i);
    `CHK(int_o, 1'b0)
    wb(0, 8'h04, 32'h0);
    `CHK(q[1], 1'b0)
    wb(0, 8'hfc, 32'h0);
    `CHK(q, 32'h0)
    $display("Test registers done");
    repeat (8) @(posedge clk_i);
    `CHK(oe, 1'b0)
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    `CHK(oe, 1'b1)
    `CHK(conv_on, 1'b0)
    rst_i <= 0;
    @(posedge clk_i);
    `CHK(state_o, 2'h0)
    @(posedge clk_i);
    `CHK(state_o, 2'h0)
    wait_st(2'h3, 6400);
    $display("Test mid-run reset done");
    wb(1, 8'h10, 32'h1);
    wb(0, 8'h10, 32'h0);
    `CHK(q, 32'h1)
    for (int i = 0; i < 4; i++) begin
      case (i)
        0: en_req <= 0;
        1: gate <= 0;
        2: ot <= 1;
        default: ctrl <= 0;
      endcase
      repeat (5) @(posedge clk_i);
      `CHK(state_o, 2'h0)
      `CHK(conv_on, 1'b0)
      `CHK(oe, 1'b1)
      en_req <= 1;
      gate <= 1;
      ot <= 0;
      ctrl <= 1;
      wait_st(2'h1, 10);
      wait_st(2'h2, 20);
      wait_st(2'h3, 3200);
    end
    // Let the window settle so no event is still being set
    repeat (12) @(posedge clk_i);
    wb(0, 8'h04, 32'h0);
    `CHK(q, 32'h1f)
    wb(1, 8'h08, 32'h1f);
    wb(0, 8'h04, 32'h0);
    `CHK(q, 32'h0)
    $display("Test fault restart done");
    strap_n <= 0;
    repeat (6) @(posedge clk_i);
    `CHK(state_o, 2'h0)
    en_req <= 0;
    wait_st(2'h1, 10);
    $display("Test polarity done");
    report_and_stop();
  end
endmodule
`default_nettype wire
